// file: mss_pkg.sv
// Functional notes
// [R01] start mode code 0 direct, 1 speed tracking, 2 pre-excited (asynchronous motors only)
// [R02] direct start with zero braking time runs at once from startup frequency
// [R03] direct start with nonzero braking time brakes first, then runs from startup frequency
// [R04] tracking restart finds motor speed and direction, then outputs tracked frequency
// [R05] pre-excited start with zero time skips pre-excitation and runs directly
// [R06] pre-excited start drives pre-excitation current for its time, up to 100.0s
// [R07] tracking start point: 0 stop frequency, 1 zero speed, 2 maximum frequency
// [R08] tracking rate accepts 1 to 100, default 20, larger tracks faster
// [R09] startup frequency 0 to 10.00 Hz, not clamped by frequency lower limit
// [R10] target below startup frequency: no start, holding state with 0.00 Hz output
// [R11] after start, startup frequency held for hold time up to 100.0s
// [R12] no startup hold when changing between forward and reverse rotation
// [R13] hold excluded from acceleration time, counted in step-program running time
// [R14] startup dc braking only in direct start mode, never otherwise
// [R15] startup braking or pre-excitation current is percent of rated current, 0 to 100
// [R16] stop mode 0 decelerates along ramp and stops at zero frequency
// [R17] stop mode 1 cuts output at once, motor coasts
// [R18] stop dc braking starts when running frequency falls to initial frequency, default 0
// [R19] output suspended for stop braking waiting time, up to 100.0s, before braking
// [R20] stop dc braking current is percent of rated current, 0 to 100
// [R21] stop braking held for stop braking time, zero time cancels it
// [R22] inching forces direct start and decelerate to stop
// [R23] all timed phases counted with a common 0.1 second tick
package mss_pkg;
  localparam int CLOCK_HZ    = 25_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  // register byte addresses
  localparam logic [7:0] ADDR_START_CFG   = 8'h00;
  localparam logic [7:0] ADDR_START_FREQ  = 8'h04;
  localparam logic [7:0] ADDR_START_TIMES = 8'h08;
  localparam logic [7:0] ADDR_START_CUR   = 8'h0C;
  localparam logic [7:0] ADDR_STOP_CFG    = 8'h10;
  localparam logic [7:0] ADDR_STOP_TIMES  = 8'h14;
  localparam logic [7:0] ADDR_STOP_CUR    = 8'h18;
  localparam logic [7:0] ADDR_MAX_FREQ    = 8'h1C;
  localparam logic [7:0] ADDR_STATUS      = 8'h20;
  localparam logic [7:0] ADDR_STOP_RECORD = 8'h24;
  // field positions
  localparam int START_MODE_LSB = 0;
  localparam int TRACK_PT_LSB   = 4;
  localparam int TRACK_RATE_LSB = 8;
  localparam int LO_LSB         = 0;
  localparam int HI_LSB         = 16;
  localparam int STOP_MODE_BIT  = 0;
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_OUT_BIT     = 4;
  localparam int ST_DC_BIT      = 5;
  localparam int ST_REV_BIT     = 6;
  // limits and reset values
  localparam logic [15:0] STARTUP_FREQ_MAX = 16'h03E8;
  localparam logic [15:0] MAX_FREQ_RESET   = 16'h1388;
  localparam logic [9:0]  TIME_MAX         = 10'h3E8;
  localparam logic [6:0]  PCT_MAX          = 7'h64;
  localparam logic [6:0]  RATE_MIN         = 7'h01;
  localparam logic [6:0]  RATE_MAX         = 7'h64;
  localparam logic [6:0]  RATE_DEFAULT     = 7'h14;
  // mode codes
  localparam logic [1:0] START_DIRECT    = 2'h0;
  localparam logic [1:0] START_TRACK     = 2'h1;
  localparam logic [1:0] START_PREEXCITE = 2'h2;
  localparam logic [1:0] TRACK_FROM_STOP = 2'h0;
  localparam logic [1:0] TRACK_FROM_ZERO = 2'h1;
  localparam logic [1:0] TRACK_FROM_MAX  = 2'h2;
  localparam logic       STOP_DECEL      = 1'b0;
  localparam logic       STOP_FREE       = 1'b1;
  typedef enum logic [3:0] {
    MSS_IDLE        = 4'h0,
    MSS_WAIT_TARGET = 4'h1,
    MSS_START_BRAKE = 4'h2,
    MSS_PREEXCITE   = 4'h3,
    MSS_TRACK       = 4'h4,
    MSS_HOLD        = 4'h5,
    MSS_RUN         = 4'h6,
    MSS_DECEL       = 4'h7,
    MSS_STOP_WAIT   = 4'h8,
    MSS_STOP_BRAKE  = 4'h9
  } mss_state_t;
endpackage

// file: mss_sequencer.sv
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module mss_sequencer #(
  parameter int          TICK_CYCLES    = mss_pkg::TICK_CYCLES,
  parameter logic [15:0] MAX_FREQ_RESET = mss_pkg::MAX_FREQ_RESET
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // run and stop command source
  input  wire logic        run_cmd,
  input  wire logic        inch_run,
  input  wire logic        reverse_cmd,
  input  wire logic [15:0] target_frequency,
  input  wire logic        async_motor,
  // feedback from ramp and speed search
  input  wire logic [15:0] running_frequency,
  input  wire logic        track_done,
  input  wire logic        tracked_reverse,
  // output stage commands
  output logic             output_enable,
  output logic             dc_brake_active,
  output logic             preexcite_active,
  output logic      [6:0]  current_percent,
  output logic      [15:0] frequency_command,
  output logic             ramp_hold,
  output logic             accel_time_enable,
  output logic             program_time_run,
  output logic             reverse_out,
  output logic             track_enable,
  output logic      [6:0]  tracking_rate_out
);
  localparam int DIV_W = $clog2(TICK_CYCLES);

  // configuration registers
  logic [1:0]  start_mode_select;
  logic [1:0]  tracking_start_point;
  logic [6:0]  tracking_rate;
  logic [15:0] startup_frequency;
  logic [9:0]  startup_hold_time;
  logic [9:0]  startup_brake_or_preexcite_time;
  logic [6:0]  startup_brake_or_preexcite_current;
  logic        stop_mode_select;
  logic [15:0] stop_brake_initial_frequency;
  logic [9:0]  stop_brake_wait_time;
  logic [9:0]  stop_brake_time;
  logic [6:0]  stop_brake_current;
  logic [15:0] max_frequency;
  logic [15:0] stop_freq_reg;
  // sequencer state
  mss_pkg::mss_state_t state_reg;
  mss_pkg::mss_state_t state_next;
  logic [DIV_W-1:0]    tick_div_reg;
  logic [9:0]          phase_count_reg;
  logic                tick;
  logic                state_change;
  logic                inch_reg;
  logic [1:0]          eff_start_mode;
  logic                eff_stop_mode;
  logic                below_start;
  logic                bus_write;
  logic                bus_setup;
  logic                addr_hit;
  logic [31:0]         read_value;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] hi);
    clamp16 = (v > hi) ? hi : v;
  endfunction

  function automatic logic [9:0] clamp_time(input logic [15:0] v);
    clamp_time = (v > 16'(mss_pkg::TIME_MAX)) ? mss_pkg::TIME_MAX : v[9:0];
  endfunction

  function automatic logic [6:0] clamp_pct(input logic [15:0] v);
    clamp_pct = (v > 16'(mss_pkg::PCT_MAX)) ? mss_pkg::PCT_MAX : v[6:0];
  endfunction

  function automatic mss_pkg::mss_state_t first_start_state(input logic [1:0] mode,
                                                           input logic [9:0] t);
    case (mode)
      mss_pkg::START_DIRECT: begin
        first_start_state = (t != 10'h000) ? mss_pkg::MSS_START_BRAKE : mss_pkg::MSS_HOLD; // see [R02] [R03] [R14]
      end
      mss_pkg::START_TRACK: begin
        first_start_state = mss_pkg::MSS_TRACK; // see [R04]
      end
      mss_pkg::START_PREEXCITE: begin
        first_start_state = (t != 10'h000) ? mss_pkg::MSS_PREEXCITE : mss_pkg::MSS_HOLD; // see [R05] [R06]
      end
      default: begin
        first_start_state = mss_pkg::MSS_HOLD;
      end
    endcase
  endfunction

  function automatic mss_pkg::mss_state_t stop_state(input logic mode);
    stop_state = (mode == mss_pkg::STOP_FREE) ? mss_pkg::MSS_IDLE : mss_pkg::MSS_DECEL; // see [R16] [R17]
  endfunction

  // apb decode
  assign bus_setup = psel & ~penable;
  assign bus_write = psel & penable & pwrite & addr_hit;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_hit;

  always_comb begin
    addr_hit   = 1'b1;
    read_value = 32'h0000_0000;
    case (paddr)
      mss_pkg::ADDR_START_CFG: begin
        read_value[mss_pkg::START_MODE_LSB +: 2] = start_mode_select;
        read_value[mss_pkg::TRACK_PT_LSB +: 2]   = tracking_start_point;
        read_value[mss_pkg::TRACK_RATE_LSB +: 7] = tracking_rate;
      end
      mss_pkg::ADDR_START_FREQ: begin
        read_value[mss_pkg::LO_LSB +: 16] = startup_frequency;
      end
      mss_pkg::ADDR_START_TIMES: begin
        read_value[mss_pkg::LO_LSB +: 10] = startup_hold_time;
        read_value[mss_pkg::HI_LSB +: 10] = startup_brake_or_preexcite_time;
      end
      mss_pkg::ADDR_START_CUR: begin
        read_value[mss_pkg::LO_LSB +: 7] = startup_brake_or_preexcite_current;
      end
      mss_pkg::ADDR_STOP_CFG: begin
        read_value[mss_pkg::STOP_MODE_BIT] = stop_mode_select;
        read_value[mss_pkg::HI_LSB +: 16]  = stop_brake_initial_frequency;
      end
      mss_pkg::ADDR_STOP_TIMES: begin
        read_value[mss_pkg::LO_LSB +: 10] = stop_brake_wait_time;
        read_value[mss_pkg::HI_LSB +: 10] = stop_brake_time;
      end
      mss_pkg::ADDR_STOP_CUR: begin
        read_value[mss_pkg::LO_LSB +: 7] = stop_brake_current;
      end
      mss_pkg::ADDR_MAX_FREQ: begin
        read_value[mss_pkg::LO_LSB +: 16] = max_frequency;
      end
      mss_pkg::ADDR_STATUS: begin
        read_value[mss_pkg::ST_STATE_LSB +: 4] = state_reg;
        read_value[mss_pkg::ST_OUT_BIT]        = output_enable;
        read_value[mss_pkg::ST_DC_BIT]         = dc_brake_active;
        read_value[mss_pkg::ST_REV_BIT]        = reverse_out;
        read_value[mss_pkg::HI_LSB +: 16]      = running_frequency;
      end
      mss_pkg::ADDR_STOP_RECORD: begin
        read_value[mss_pkg::LO_LSB +: 16] = stop_freq_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (bus_setup) begin
      prdata <= read_value;
    end
  end

  // start configuration writes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      start_mode_select                  <= mss_pkg::START_DIRECT;
      tracking_start_point               <= mss_pkg::TRACK_FROM_STOP;
      tracking_rate                      <= mss_pkg::RATE_DEFAULT;
      startup_frequency                  <= 16'h0000;
      startup_hold_time                  <= 10'h000;
      startup_brake_or_preexcite_time    <= 10'h000;
      startup_brake_or_preexcite_current <= 7'h00;
    end else if (bus_write) begin
      case (paddr)
        mss_pkg::ADDR_START_CFG: begin
          start_mode_select    <= pwdata[mss_pkg::START_MODE_LSB +: 2]; // see [R01]
          tracking_start_point <= pwdata[mss_pkg::TRACK_PT_LSB +: 2]; // see [R07]
          if (pwdata[mss_pkg::TRACK_RATE_LSB +: 7] < mss_pkg::RATE_MIN) begin
            tracking_rate <= mss_pkg::RATE_MIN; // see [R08]
          end else begin
            tracking_rate <= clamp_pct({9'h000, pwdata[mss_pkg::TRACK_RATE_LSB +: 7]}); // see [R08]
          end
        end
        mss_pkg::ADDR_START_FREQ: begin
          startup_frequency <= clamp16(pwdata[mss_pkg::LO_LSB +: 16], mss_pkg::STARTUP_FREQ_MAX); // see [R09]
        end
        mss_pkg::ADDR_START_TIMES: begin
          startup_hold_time               <= clamp_time(pwdata[mss_pkg::LO_LSB +: 16]); // see [R11]
          startup_brake_or_preexcite_time <= clamp_time(pwdata[mss_pkg::HI_LSB +: 16]); // see [R06]
        end
        mss_pkg::ADDR_START_CUR: begin
          startup_brake_or_preexcite_current <= clamp_pct(pwdata[mss_pkg::LO_LSB +: 16]); // see [R15]
        end
        default: begin
        end
      endcase
    end
  end

  // stop configuration writes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stop_mode_select             <= mss_pkg::STOP_DECEL;
      stop_brake_initial_frequency <= 16'h0000;
      stop_brake_wait_time         <= 10'h000;
      stop_brake_time              <= 10'h000;
      stop_brake_current           <= 7'h00;
      max_frequency                <= MAX_FREQ_RESET;
    end else if (bus_write) begin
      case (paddr)
        mss_pkg::ADDR_STOP_CFG: begin
          stop_mode_select             <= pwdata[mss_pkg::STOP_MODE_BIT];
          stop_brake_initial_frequency <= clamp16(pwdata[mss_pkg::HI_LSB +: 16], max_frequency); // see [R18]
        end
        mss_pkg::ADDR_STOP_TIMES: begin
          stop_brake_wait_time <= clamp_time(pwdata[mss_pkg::LO_LSB +: 16]); // see [R19]
          stop_brake_time      <= clamp_time(pwdata[mss_pkg::HI_LSB +: 16]); // see [R21]
        end
        mss_pkg::ADDR_STOP_CUR: begin
          stop_brake_current <= clamp_pct(pwdata[mss_pkg::LO_LSB +: 16]); // see [R20]
        end
        mss_pkg::ADDR_MAX_FREQ: begin
          max_frequency <= pwdata[mss_pkg::LO_LSB +: 16];
        end
        default: begin
        end
      endcase
    end
  end

  // inching latched for the whole run
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inch_reg <= 1'b0;
    end else if (state_reg == mss_pkg::MSS_IDLE) begin
      inch_reg <= inch_run;
    end
  end

  // effective modes
  always_comb begin
    if (inch_run || inch_reg) begin
      eff_start_mode = mss_pkg::START_DIRECT; // see [R22]
    end else if (start_mode_select == mss_pkg::START_PREEXCITE && !async_motor) begin
      eff_start_mode = mss_pkg::START_DIRECT; // see [R01]
    end else begin
      eff_start_mode = start_mode_select;
    end
    eff_stop_mode = inch_reg ? mss_pkg::STOP_DECEL : stop_mode_select; // see [R22]
  end

  assign below_start  = target_frequency < startup_frequency; // see [R09] [R10]
  assign state_change = state_next != state_reg;
  assign tick         = tick_div_reg == DIV_W'(TICK_CYCLES - 1);

  // 0.1 s tick and phase counter, restarted on every state change
  always_ff @(posedge clock) begin
    if (!reset_n || state_change) begin
      tick_div_reg    <= '0;
      phase_count_reg <= 10'h000;
    end else if (tick) begin
      tick_div_reg <= '0;
      if (phase_count_reg != mss_pkg::TIME_MAX) begin
        phase_count_reg <= phase_count_reg + 10'h001; // see [R23]
      end
    end else begin
      tick_div_reg <= tick_div_reg + DIV_W'(1);
    end
  end

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mss_pkg::MSS_IDLE: begin
        if (run_cmd || inch_run) begin
          state_next = below_start ? mss_pkg::MSS_WAIT_TARGET
                                   : first_start_state(eff_start_mode, startup_brake_or_preexcite_time);
        end
      end
      mss_pkg::MSS_WAIT_TARGET: begin
        if (!(run_cmd || inch_run)) begin
          state_next = mss_pkg::MSS_IDLE;
        end else if (!below_start) begin
          state_next = first_start_state(eff_start_mode, startup_brake_or_preexcite_time); // see [R10]
        end
      end
      mss_pkg::MSS_START_BRAKE, mss_pkg::MSS_PREEXCITE: begin
        if (!(run_cmd || inch_run)) begin
          state_next = mss_pkg::MSS_IDLE;
        end else if (phase_count_reg >= startup_brake_or_preexcite_time) begin
          state_next = mss_pkg::MSS_HOLD; // see [R03] [R06]
        end
      end
      mss_pkg::MSS_TRACK: begin
        if (!(run_cmd || inch_run)) begin
          state_next = mss_pkg::MSS_IDLE;
        end else if (track_done) begin
          state_next = mss_pkg::MSS_RUN; // see [R04]
        end
      end
      mss_pkg::MSS_HOLD: begin
        if (!(run_cmd || inch_run)) begin
          state_next = stop_state(eff_stop_mode);
        end else if (phase_count_reg >= startup_hold_time) begin
          state_next = mss_pkg::MSS_RUN; // see [R11]
        end
      end
      mss_pkg::MSS_RUN: begin
        if (!(run_cmd || inch_run)) begin
          state_next = stop_state(eff_stop_mode);
        end
      end
      mss_pkg::MSS_DECEL: begin
        if (run_cmd || inch_run) begin
          state_next = mss_pkg::MSS_RUN;
        end else if (stop_brake_time != 10'h000 && running_frequency <= stop_brake_initial_frequency) begin
          state_next = mss_pkg::MSS_STOP_WAIT; // see [R18] [R21]
        end else if (running_frequency == 16'h0000) begin
          state_next = mss_pkg::MSS_IDLE; // see [R16]
        end
      end
      mss_pkg::MSS_STOP_WAIT: begin
        if (phase_count_reg >= stop_brake_wait_time) begin
          state_next = mss_pkg::MSS_STOP_BRAKE; // see [R19]
        end
      end
      mss_pkg::MSS_STOP_BRAKE: begin
        if (phase_count_reg >= stop_brake_time) begin
          state_next = mss_pkg::MSS_IDLE; // see [R21]
        end
      end
      default: begin
        state_next = mss_pkg::MSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= mss_pkg::MSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // frequency at stop, origin of a later speed search
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stop_freq_reg <= 16'h0000;
    end else if ((state_reg == mss_pkg::MSS_RUN || state_reg == mss_pkg::MSS_HOLD ||
                  state_reg == mss_pkg::MSS_DECEL) &&
                 (state_next == mss_pkg::MSS_IDLE || state_next == mss_pkg::MSS_STOP_WAIT)) begin
      stop_freq_reg <= running_frequency;
    end
  end

  // direction: follows command while running, no hold on reversal
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reverse_out <= 1'b0;
    end else if (state_reg == mss_pkg::MSS_TRACK) begin
      if (track_done) begin
        reverse_out <= tracked_reverse; // see [R04]
      end
    end else begin
      reverse_out <= reverse_cmd; // see [R12]
    end
  end

  // output stage commands registered from the next state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      output_enable     <= 1'b0;
      dc_brake_active   <= 1'b0;
      preexcite_active  <= 1'b0;
      current_percent   <= 7'h00;
      frequency_command <= 16'h0000;
      ramp_hold         <= 1'b0;
      accel_time_enable <= 1'b0;
      program_time_run  <= 1'b0;
      track_enable      <= 1'b0;
      tracking_rate_out <= mss_pkg::RATE_DEFAULT;
    end else begin
      output_enable     <= 1'b0;
      dc_brake_active   <= 1'b0;
      preexcite_active  <= 1'b0;
      current_percent   <= 7'h00;
      frequency_command <= 16'h0000; // see [R10] [R17]
      ramp_hold         <= 1'b0;
      accel_time_enable <= 1'b0;
      program_time_run  <= 1'b0;
      track_enable      <= 1'b0;
      tracking_rate_out <= tracking_rate; // see [R08]
      case (state_next)
        mss_pkg::MSS_START_BRAKE: begin
          output_enable   <= 1'b1;
          dc_brake_active <= 1'b1; // see [R14]
          current_percent <= startup_brake_or_preexcite_current; // see [R15]
        end
        mss_pkg::MSS_PREEXCITE: begin
          output_enable    <= 1'b1;
          preexcite_active <= 1'b1; // see [R06]
          current_percent  <= startup_brake_or_preexcite_current; // see [R15]
        end
        mss_pkg::MSS_TRACK: begin
          output_enable <= 1'b1;
          track_enable  <= 1'b1;
          ramp_hold     <= 1'b1;
          case (tracking_start_point)
            mss_pkg::TRACK_FROM_STOP: frequency_command <= stop_freq_reg; // see [R07]
            mss_pkg::TRACK_FROM_MAX:  frequency_command <= max_frequency; // see [R07]
            default:                  frequency_command <= 16'h0000; // see [R07]
          endcase
        end
        mss_pkg::MSS_HOLD: begin
          output_enable     <= 1'b1;
          ramp_hold         <= 1'b1;
          frequency_command <= startup_frequency; // see [R11]
          program_time_run  <= 1'b1; // see [R13]
        end
        mss_pkg::MSS_RUN: begin
          output_enable     <= 1'b1;
          frequency_command <= target_frequency;
          accel_time_enable <= 1'b1; // see [R13]
          program_time_run  <= 1'b1; // see [R13]
        end
        mss_pkg::MSS_DECEL: begin
          output_enable     <= 1'b1;
          accel_time_enable <= 1'b1; // see [R16]
        end
        mss_pkg::MSS_STOP_BRAKE: begin
          output_enable   <= 1'b1;
          dc_brake_active <= 1'b1;
          current_percent <= stop_brake_current; // see [R20]
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// file: mss_sequencer_props.sv
`timescale 1ns/10ps
module mss_sequencer_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // command side
  input wire logic        run_cmd,
  input wire logic        inch_run,
  input wire logic        async_motor,
  input wire logic        track_done,
  // stage side
  input wire logic        output_enable,
  input wire logic        dc_brake_active,
  input wire logic        preexcite_active,
  input wire logic [6:0]  current_percent,
  input wire logic [15:0] frequency_command,
  input wire logic        ramp_hold,
  input wire logic        accel_time_enable,
  input wire logic        program_time_run,
  input wire logic        track_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  off_freq_zero_a: assert property (!output_enable |-> frequency_command == 16'h0000)
    else $error("frequency command while output off");
  idle_cur_zero_a: assert property (!dc_brake_active && !preexcite_active |-> current_percent == 7'h00)
    else $error("current without brake or excitation");
  brake_output_a: assert property (dc_brake_active |-> output_enable && !ramp_hold && !accel_time_enable)
    else $error("brake with ramp active");
  preexcite_async_a: assert property (preexcite_active |-> async_motor && output_enable && !dc_brake_active)
    else $error("pre-excitation on wrong motor");
  hold_no_accel_a: assert property (ramp_hold && !track_enable |-> !accel_time_enable && program_time_run)
    else $error("hold counted as acceleration");
  track_to_run_a: assert property (track_enable && track_done && (run_cmd || inch_run)
    |=> !track_enable && !ramp_hold && accel_time_enable)
    else $error("tracking did not end in run");
  prog_time_a: assert property (program_time_run |-> output_enable && !dc_brake_active && !track_enable)
    else $error("program time outside hold or run");
  start_cause_a: assert property ($rose(output_enable) && !dc_brake_active |-> $past(run_cmd || inch_run))
    else $error("output started without run");
endmodule
bind mss_sequencer mss_sequencer_props u_mss_sequencer_props (.*);

// file: mss_far_side.sv
`timescale 1ns/10ps
module mss_far_side (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // commands
  input  wire logic        output_enable,
  input  wire logic        ramp_hold,
  input  wire logic        track_enable,
  input  wire logic [15:0] frequency_command,
  // feedback
  output logic      [15:0] running_frequency,
  output logic             track_done,
  output logic             tracked_reverse
);
  logic [3:0] search_reg;
  // ramp one step a cycle, jump while held
  always_ff @(posedge clock) begin
    if (!reset_n || !output_enable) running_frequency <= 16'h0000;
    else if (ramp_hold || running_frequency == frequency_command) running_frequency <= frequency_command;
    else running_frequency <= running_frequency + ((running_frequency < frequency_command) ? 16'h0001 : 16'hFFFF);
  end
  // speed search, direction only valid with done
  always_ff @(posedge clock) begin
    search_reg <= (reset_n && track_enable && !track_done) ? search_reg + 4'h1 : 4'h0;
    track_done <= reset_n && search_reg == 4'hC;
    tracked_reverse <= !reset_n ? 1'b0 : (search_reg == 4'hC) ? 1'b1 : ~tracked_reverse;
  end
endmodule

// file: mss_sequencer_tb_top.sv
`timescale 1ns/10ps
module mss_sequencer_tb_top;
  localparam logic [31:0] cfg_c[7] = '{32'h6421, 32'h1F4, 32'h20002, 32'h28, 32'h12C0000, 32'h20002, 32'h1E};
  localparam logic [7:0]  first_c[4] = '{8'h32, 8'h14, 8'h13, 8'h32};
  logic        clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        run_cmd = 1'b0, inch_run = 1'b0, reverse_cmd = 1'b0, async_motor = 1'b0;
  logic        pready, pslverr, track_done, tracked_reverse, output_enable, dc_brake_active, reverse_out;
  logic        preexcite_active, ramp_hold, accel_time_enable, program_time_run, track_enable;
  logic [6:0]  current_percent, tracking_rate_out;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] target_frequency = 16'h0, running_frequency, frequency_command;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [31:0] mask_q[$];
  logic [32:0] exp_q[$];
  int          fail_count = 0, compares = 0;
  mss_sequencer #(.TICK_CYCLES(4)) u_mss_sequencer (.*);
  mss_far_side u_mss_far_side (.*);
  always #20 clock = ~clock;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [32:0] e);
    mask_q.push_back(m);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data watcher
  always @(negedge clock) begin
    if (psel && penable && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata & mask_q.pop_front()}, exp_q.pop_front(), "read");
    end
  end
  initial begin
    #1600000;
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hAB46));
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    rd(8'h00, 32'hFFFFFFFF, 33'h1400);
    rd(8'h1C, 32'hFFFFFFFF, 33'h1388);
    rd(8'h28, 32'hFFFFFFFF, 33'h100000000);
    for (int i = 0; i < 7; i++) apb(1'b1, 8'(4 * i), cfg_c[i]);
    rd(8'h00, 32'hFFFFFFFF, 33'h6421);
    $display("registers done");
    target_frequency <= 16'h00C8;
    run_cmd <= 1'b1;
    rd(8'h20, 32'h1F, 33'h01);
    run_cmd <= 1'b0;
    target_frequency <= 16'($urandom_range(600, 1500));
    $display("low target done");
    for (int m = 0; m < 4; m++) begin
      async_motor <= (m == 2);
      apb(1'b1, 8'h00, 32'h6420 | 32'((m == 3) ? 2 : m));
      run_cmd <= 1'b1;
      wait (output_enable === 1'b1);
      rd(8'h20, 32'h3F, 33'(first_c[m]));
      if (m == 1) begin
        check(33'(frequency_command), 33'h1388, "origin");
        wait (accel_time_enable === 1'b1);
      end
      @(posedge clock);
      run_cmd <= 1'b0;
      wait (output_enable === 1'b0);
      if (m == 1) begin
        wait (dc_brake_active === 1'b1);
        wait (dc_brake_active === 1'b0);
      end
    end
    $display("start modes done");
    apb(1'b1, 8'h00, 32'h6420);
    run_cmd <= 1'b1;
    wait (ramp_hold === 1'b1);
    rd(8'h20, 32'h3F, 33'h15);
    check(33'(frequency_command), 33'h1F4, "startup");
    wait (accel_time_enable === 1'b1);
    rd(8'h20, 32'h3F, 33'h16);
    check(33'(frequency_command), 33'(target_frequency), "target");
    run_cmd <= 1'b0;
    rd(8'h20, 32'h3F, 33'h17);
    wait (output_enable === 1'b0);
    rd(8'h20, 32'h3F, 33'h08);
    wait (dc_brake_active === 1'b1);
    rd(8'h20, 32'h3F, 33'h39);
    check(33'(current_percent), 33'h1E, "stop current");
    wait (output_enable === 1'b0);
    rd(8'h20, 32'h3F, 33'h00);
    $display("stop braking done");
    apb(1'b1, 8'h10, 32'h12C0001);
    apb(1'b1, 8'h00, 32'h6421);
    inch_run <= 1'b1;
    wait (output_enable === 1'b1);
    rd(8'h20, 32'h3F, 33'h32);
    wait (accel_time_enable === 1'b1);
    @(posedge clock);
    inch_run <= 1'b0;
    rd(8'h20, 32'h3F, 33'h17);
    wait (dc_brake_active === 1'b1);
    wait (dc_brake_active === 1'b0);
    run_cmd <= 1'b1;
    wait (accel_time_enable === 1'b1);
    @(posedge clock);
    run_cmd <= 1'b0;
    rd(8'h20, 32'h3F, 33'h00);
    $display("inching and free stop done");
    end_of_test();
  end
endmodule
